//--- inc/rro_defs.vh
/*
 * Constants for the return, rotate and software reset execution block.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef RRO_DEFS_VH
`define RRO_DEFS_VH

// ----------------------------------------
// Operation codes presented by the decoder
// ----------------------------------------
`define RRO_OP_W 3
`define RRO_OP_NONE 3'h0
`define RRO_OP_SW_RESET 3'h1
`define RRO_OP_INTERRUPT_EXIT 3'h2
`define RRO_OP_SUB_RETURN 3'h3
`define RRO_OP_LITERAL_RETURN 3'h4
`define RRO_OP_ROTATE_LEFT 3'h5
`define RRO_OP_ROTATE_RIGHT 3'h6

// ----------------------------------------
// Widths and field positions
// ----------------------------------------
`define RRO_PC_W 15
`define RRO_DATA_W 8
`define RRO_FADDR_W 7
`define RRO_MSB 7
`define RRO_LSB 0
`define RRO_GIE_BIT 3'h7
`define RRO_DEST_W 1'b0
`define RRO_DEST_F 1'b1

// ----------------------------------------
// Sequencer states and reset values
// ----------------------------------------
`define RRO_ST_IDLE 1'b0
`define RRO_ST_FLUSH 1'b1
`define RRO_PC_RST 15'h0000
`define RRO_W_RST 8'h00
`define RRO_ZERO8 8'h00

`endif

//--- hw/rro_rotate.v
/*
 * Rotate-through-carry datapath, one cycle, purely combinational.
 * Assumes the caller registers the results and applies them on its own clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rro_defs.vh"

module rro_rotate (
   input wire [7:0] operand_in, // File register value
   input wire carry_in, // Current carry
   input wire left_in, // 1 rotate left, 0 rotate right
   output reg [7:0] result_out, // Rotated byte
   output reg carry_out // New carry
);

   // Nine-bit ring made of the byte and carry
   always @* begin
      if (left_in) begin
         result_out = {operand_in[`RRO_MSB-1:`RRO_LSB], carry_in};
         carry_out = operand_in[`RRO_MSB];
      end else begin
         result_out = {carry_in, operand_in[`RRO_MSB:`RRO_LSB+1]};
         carry_out = operand_in[`RRO_LSB];
      end
   end

endmodule // rro_rotate
`default_nettype wire

//--- hw/rro_exec.v
/*
 * Execution unit for software reset, the three returns and both rotates.
 * Assumes the decoder supplies one operation per instruction cycle on
 * op_valid_in, with the stack head value already present on stack_head_in,
 * and that it honours busy_out by holding off the next instruction.
 * File register data arrives from the same clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rro_defs.vh"

module rro_exec (
   input wire sys_clk_in, // Instruction cycle clock
   input wire reset_in, // Synchronous reset, active high
   input wire op_valid_in, // Operation present this cycle
   input wire [2:0] op_code_in, // Operation code
   input wire [7:0] literal_in, // Literal operand
   input wire [6:0] faddr_in, // File register address
   input wire dest_in, // Destination select
   input wire [7:0] fdata_in, // File register read data
   input wire [14:0] stack_head_in, // Stack head value
   input wire carry_in, // Current carry flag
   output reg busy_out, // Second cycle of a return in progress
   output reg pc_load_out, // Load program counter pulse
   output reg [14:0] pc_value_out, // Program counter value
   output reg stack_pop_out, // Pop stack pulse
   output reg w_we_out, // Working register write pulse
   output reg [7:0] w_data_out, // Working register data
   output reg f_we_out, // File register write pulse
   output reg [6:0] f_waddr_out, // File register write address
   output reg [7:0] f_wdata_out, // File register write data
   output reg carry_we_out, // Carry write pulse
   output reg carry_out, // New carry value
   output reg global_irq_on_set_out, // Set interrupt control bit 7 pulse
   output reg [2:0] global_irq_on_bit_out, // Bit index within control register
   output reg sw_reset_flag_clr_out, // Clear software reset flag pulse
   output reg device_reset_req_out // Full device reset request pulse
);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   localparam ST_IDLE = `RRO_ST_IDLE;
   localparam ST_FLUSH = `RRO_ST_FLUSH;

   reg state;
   reg next_state;
   wire accept;
   wire is_return;
   wire is_rotate;
   wire [7:0] rot_result;
   wire rot_carry;
   reg next_busy;
   reg next_pc_load;
   reg [14:0] next_pc_value;
   reg next_stack_pop;
   reg next_w_we;
   reg [7:0] next_w_data;
   reg next_f_we;
   reg [6:0] next_f_waddr;
   reg [7:0] next_f_wdata;
   reg next_carry_we;
   reg next_carry;
   reg next_irq_on_set;
   reg next_flag_clr;
   reg next_reset_req;

   // New work is ignored while a return is flushing its second cycle
   assign accept = op_valid_in && (state == ST_IDLE);
   assign is_return = (op_code_in == `RRO_OP_INTERRUPT_EXIT) ||
                      (op_code_in == `RRO_OP_SUB_RETURN) ||
                      (op_code_in == `RRO_OP_LITERAL_RETURN);
   assign is_rotate = (op_code_in == `RRO_OP_ROTATE_LEFT) ||
                      (op_code_in == `RRO_OP_ROTATE_RIGHT);

   always @* begin
      case (state)
         ST_IDLE: begin
            if (accept && is_return) begin
               next_state = ST_FLUSH;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_FLUSH: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Rotate datapath
   // ----------------------------------------
   rro_rotate u_rotate (
      .operand_in(fdata_in),
      .carry_in(carry_in),
      .left_in(op_code_in == `RRO_OP_ROTATE_LEFT),
      .result_out(rot_result),
      .carry_out(rot_carry)
   );

   // ----------------------------------------
   // Next values of the effect outputs
   // ----------------------------------------
   // Pulses fall back to zero each cycle; data outputs hold their last value
   always @* begin
      // Busy covers exactly the dead second cycle of a return
      next_busy = (next_state == ST_FLUSH);
      next_pc_load = 1'b0;
      next_pc_value = pc_value_out;
      next_stack_pop = 1'b0;
      next_w_we = 1'b0;
      next_w_data = w_data_out;
      next_f_we = 1'b0;
      next_f_waddr = f_waddr_out;
      next_f_wdata = f_wdata_out;
      next_carry_we = 1'b0;
      next_carry = carry_out;
      next_irq_on_set = 1'b0;
      next_flag_clr = 1'b0;
      next_reset_req = 1'b0;
      if (accept) begin
         if (is_return) begin
            // No status flag strobe on any return path
            next_pc_load = 1'b1;
            next_pc_value = stack_head_in;
            next_stack_pop = 1'b1;
         end
         case (op_code_in)
            `RRO_OP_SW_RESET: begin
               next_reset_req = 1'b1;
               next_flag_clr = 1'b1;
            end
            `RRO_OP_INTERRUPT_EXIT: begin
               next_irq_on_set = 1'b1;
            end
            `RRO_OP_LITERAL_RETURN: begin
               next_w_we = 1'b1;
               next_w_data = literal_in;
            end
            default: begin
               if (is_rotate) begin
                  // Only carry among the status bits is written
                  next_carry_we = 1'b1;
                  next_carry = rot_carry;
                  if (dest_in == `RRO_DEST_W) begin
                     next_w_we = 1'b1;
                     next_w_data = rot_result;
                  end else begin
                     next_f_we = 1'b1;
                     next_f_waddr = faddr_in;
                     next_f_wdata = rot_result;
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Registered effects
   // ----------------------------------------
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         state <= ST_IDLE;
         busy_out <= 1'b0;
         pc_load_out <= 1'b0;
         pc_value_out <= `RRO_PC_RST;
         stack_pop_out <= 1'b0;
         w_we_out <= 1'b0;
         w_data_out <= `RRO_W_RST;
         f_we_out <= 1'b0;
         f_waddr_out <= {`RRO_FADDR_W{1'b0}};
         f_wdata_out <= `RRO_ZERO8;
         carry_we_out <= 1'b0;
         carry_out <= 1'b0;
         global_irq_on_set_out <= 1'b0;
         global_irq_on_bit_out <= `RRO_GIE_BIT;
         sw_reset_flag_clr_out <= 1'b0;
         device_reset_req_out <= 1'b0;
      end else begin
         state <= next_state;
         busy_out <= next_busy;
         global_irq_on_bit_out <= `RRO_GIE_BIT;
         pc_load_out <= next_pc_load;
         pc_value_out <= next_pc_value;
         stack_pop_out <= next_stack_pop;
         w_we_out <= next_w_we;
         w_data_out <= next_w_data;
         f_we_out <= next_f_we;
         f_waddr_out <= next_f_waddr;
         f_wdata_out <= next_f_wdata;
         carry_we_out <= next_carry_we;
         carry_out <= next_carry;
         global_irq_on_set_out <= next_irq_on_set;
         sw_reset_flag_clr_out <= next_flag_clr;
         device_reset_req_out <= next_reset_req;
      end
   end

endmodule // rro_exec
`default_nettype wire

//--- test/rro_exec_sva.sv
/* Checker for rro_exec: each taken op shows its effects one cycle later.
   Assumes binding to rro_exec; returns take a second, busy cycle. */
`timescale 1ns/10ps
`default_nettype none
module rro_exec_sva (
   input wire logic sys_clk_in, // Clock
   input wire logic reset_in, // Reset
   input wire logic op_valid_in, // Op valid
   input wire logic [2:0] op_code_in, // Op code
   input wire logic [7:0] literal_in, // Literal
   input wire logic [6:0] faddr_in, // File addr
   input wire logic dest_in, // Dest select
   input wire logic [7:0] fdata_in, // File data
   input wire logic [14:0] stack_head_in, // Stack head
   input wire logic carry_in, // Carry
   input wire logic busy_out, // Busy
   input wire logic pc_load_out, // PC load
   input wire logic [14:0] pc_value_out, // PC value
   input wire logic stack_pop_out, // Pop
   input wire logic w_we_out, // W write
   input wire logic [7:0] w_data_out, // W data
   input wire logic f_we_out, // F write
   input wire logic [6:0] f_waddr_out, // F addr
   input wire logic [7:0] f_wdata_out, // F data
   input wire logic carry_we_out, // Carry write
   input wire logic carry_out, // Carry value
   input wire logic global_irq_on_set_out, // Irq enable set
   input wire logic [2:0] global_irq_on_bit_out, // Irq bit
   input wire logic sw_reset_flag_clr_out, // Flag clear
   input wire logic device_reset_req_out // Reset request
);
default clocking @(posedge sys_clk_in); endclocking
default disable iff (reset_in);
// ----------------------------------------
// Decode of a taken op
// ----------------------------------------
wire tk = op_valid_in & ~busy_out;
wire rt = tk & (op_code_in inside {[3'h2:3'h4]});
wire ro = tk & (op_code_in inside {[3'h5:3'h6]});
wire lf = op_code_in == 3'h5;
wire [7:0] rs = lf ? {fdata_in[6:0], carry_in} : {carry_in, fdata_in[7:1]};
wire cs = lf ? fdata_in[7] : fdata_in[0];
ret_pop_a:
   assert property (rt |=> pc_load_out && stack_pop_out && pc_value_out == $past(stack_head_in))
   else $error("return pop wrong");
ret_busy_a:
   assert property (rt |=> busy_out ##1 !busy_out && !pc_load_out) else $error("return length");
ret_flags_a:
   assert property (rt |=> !carry_we_out && !f_we_out) else $error("return touched flags");
irq_on_a:
   assert property (tk && op_code_in == 3'h2 |=> global_irq_on_set_out
      && global_irq_on_bit_out == 3'h7) else $error("irq enable not set");
lit_w_a:
   assert property (tk && op_code_in == 3'h4 |=> w_we_out && w_data_out == $past(literal_in))
   else $error("literal not in w");
rot_data_a:
   assert property (ro |=> carry_we_out && carry_out == $past(cs)
      && (w_we_out ? w_data_out : f_wdata_out) == $past(rs)) else $error("rotate data");
rot_dest_a:
   assert property (ro |=> f_we_out == $past(dest_in) && w_we_out != f_we_out
      && (!f_we_out || f_waddr_out == $past(faddr_in))) else $error("rotate dest");
rot_one_a:
   assert property (ro |=> !busy_out && !pc_load_out) else $error("rotate not one cycle");
sw_reset_a:
   assert property (tk && op_code_in == 3'h1 |=> sw_reset_flag_clr_out && device_reset_req_out)
   else $error("sw reset missing");
busy_drop_a:
   assert property (busy_out |=> !carry_we_out && !w_we_out && !device_reset_req_out)
   else $error("op taken while busy");
endmodule // rro_exec_sva
bind rro_exec rro_exec_sva chk (.*);
`default_nettype wire

//--- test/tb.sv
/* Self-checking bench for rro_exec: rotates, returns and software reset.
   Assumes the exec unit and its bound checker are compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
`include "rro_defs.vh"
module tb;
logic clk = 1'b0, rst = 1'b1, v = 1'b0, d = 1'b0, c = 1'b0;
logic [2:0] op = 3'h0, gb;
logic [7:0] k = 8'h00, fd = 8'h00, wd, fwd;
logic [6:0] fa = 7'h00, fwa;
logic [14:0] sh = 15'h0000, pcv;
logic bz, pl, sp, wwe, fwe, cwe, co, gs, sc, dr;
int fails = 0, num_checks = 0;
rro_exec dut (.sys_clk_in(clk), .reset_in(rst), .op_valid_in(v), .op_code_in(op),
   .literal_in(k), .faddr_in(fa), .dest_in(d), .fdata_in(fd), .stack_head_in(sh),
   .carry_in(c), .busy_out(bz), .pc_load_out(pl), .pc_value_out(pcv), .stack_pop_out(sp),
   .w_we_out(wwe), .w_data_out(wd), .f_we_out(fwe), .f_waddr_out(fwa), .f_wdata_out(fwd),
   .carry_we_out(cwe), .carry_out(co), .global_irq_on_set_out(gs), .global_irq_on_bit_out(gb),
   .sw_reset_flag_clr_out(sc), .device_reset_req_out(dr));
initial begin
   forever #5 clk = ~clk;
end
// ----------------------------------------
// Shared drivers and compare
// ----------------------------------------
task automatic chk(input string n, input logic [14:0] s, input logic [14:0] e);
   num_checks++;
   if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
   end
endtask
task automatic step(input logic [2:0] o, input logic [7:0] kk, input logic [6:0] a,
   input logic dd, input logic [7:0] f, input logic cc, input logic [14:0] s);
   v = 1'b1;
   op = o;
   k = kk;
   fa = a;
   d = dd;
   fd = f;
   c = cc;
   sh = s;
   @(posedge clk);
   #1;
endtask
task automatic idle;
   v = 1'b0;
   @(posedge clk);
   #1;
endtask
task automatic t_rot;
   logic [7:0] f, r;
   for (int i = 0; i < 8; i++) begin
      f = 8'he6 ^ {5'h00, i[2:0]};
      r = i[0] ? {i[2], f[7:1]} : {f[6:0], i[2]};
      step(i[0] ? `RRO_OP_ROTATE_RIGHT : `RRO_OP_ROTATE_LEFT, 8'h00, {7{i[0]}}, i[1], f, i[2],
         15'h0000);
      chk("carry", {14'h0, co}, {14'h0, i[0] ? f[0] : f[7]});
      chk("dest", {13'h0, wwe, fwe}, {13'h0, ~i[1], i[1]});
      chk("result", {7'h0, i[1] ? fwd : wd}, {7'h0, r});
      if (i[1]) chk("faddr", {8'h0, fwa}, {8'h0, {7{i[0]}}});
      chk("one cycle", {13'h0, bz, cwe}, 15'h0001);
   end
   idle;
endtask
task automatic t_ret;
   for (int i = 2; i < 5; i++) begin
      step(i[2:0], 8'ha5 + i[7:0], 7'h00, 1'b0, 8'h00, 1'b0, 15'h7ffd + i[14:0]);
      chk("pop", {12'h0, pl, sp, bz}, 15'h0007);
      chk("pc", pcv, 15'h7ffd + i[14:0]);
      chk("irq on", {11'h0, gs, gb}, (i == 2) ? 15'h000f : 15'h0007);
      chk("w write", {13'h0, wwe, cwe}, (i == 4) ? 15'h0002 : 15'h0000);
      if (i == 4) chk("literal", {7'h0, wd}, 15'h00a9);
      step(`RRO_OP_ROTATE_LEFT, 8'h00, 7'h01, 1'b1, 8'hff, 1'b1, 15'h0000);
      chk("dropped", {12'h0, pl, cwe, bz}, 15'h0000);
   end
   idle;
endtask
task automatic t_swr;
   for (int i = 0; i < 4; i++) begin
      step((i < 2) ? `RRO_OP_SW_RESET : {3{i[0]}}, 8'h00, 7'h00, 1'b0, 8'h00, 1'b0, 15'h0000);
      chk("swr", {9'h0, sc, dr, pl, wwe, fwe, cwe}, (i < 2) ? 15'h0030 : 15'h0000);
   end
   idle;
endtask
task automatic t_rst;
   step(`RRO_OP_SUB_RETURN, 8'h00, 7'h00, 1'b0, 8'h00, 1'b0, 15'h1234);
   chk("busy before reset", {14'h0, bz}, 15'h0001);
   rst = 1'b1;
   idle;
   chk("mid reset", {7'h0, bz, pl, sp, wwe, fwe, gb}, 15'h0007);
   rst = 1'b0;
   step(`RRO_OP_ROTATE_RIGHT, 8'h00, 7'h05, 1'b1, 8'h81, 1'b0, 15'h0000);
   chk("rotate after reset", {3'h0, bz, cwe, fwe, co, fwd}, 15'h0740);
   chk("faddr after reset", {8'h0, fwa}, 15'h0005);
   idle;
endtask
task automatic report_and_stop;
   $display("checks %0d mismatches %0d", num_checks, fails);
   if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
   end else begin
      $display("Regression broken");
   end
   $finish;
endtask
initial begin
   #20000;
   fails++;
   report_and_stop;
end
initial begin
   repeat (8) @(posedge clk);
   #1;
   rst = 1'b0;
   chk("reset", {7'h0, bz, pl, sp, wwe, fwe, gb}, 15'h0007);
   t_rot;
   t_ret;
   t_swr;
   t_rst;
   report_and_stop;
end
endmodule // tb
`default_nettype wire
